//--- etmm_defs.svh
// Constants for the emulator trace and memory map block
`ifndef ETMM_DEFS_SVH
`define ETMM_DEFS_SVH
`define ETMM_TRACE_DEPTH 255
`define ETMM_TRACE_WIDTH 44
`define ETMM_PROG_BLOCKS 16
`define ETMM_BLOCK_BYTES 256
`define ETMM_DATA_BYTES 384
`define ETMM_BRK_COUNT 3
`define ETMM_BRK_WIDTH 15
`define ETMM_CYC_WIDTH 32
`define ETMM_PTR_RST 8'h00
`define ETMM_CYC_RST 32'h0000_0000
`endif

//--- etmm_pkg.sv
// Types for the emulator trace and memory map block
package etmm_pkg;
  typedef enum logic [1:0] {
    ETMM_IDLE = 2'b00,
    ETMM_RUN = 2'b01,
    ETMM_STOP = 2'b11
  } etmm_state_t;
  typedef struct packed {
    logic [7:0] instr;
    logic [11:0] pc;
    logic [7:0] bus0;
    logic [7:0] port1;
    logic [7:0] port2;
  } etmm_entry_t;
endpackage : etmm_pkg

//--- etmm_brk_cmp.sv
// One loadable break comparator
`timescale 1ns/1ps
module etmm_brk_cmp #(
  parameter int W = 15
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic armed,
  input wire logic [W-1:0] probe,
  output logic hit
);
  logic [W-1:0] val_q;
  logic arm_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      val_q <= '0;
      arm_q <= 1'b0;
    end else if (ce && load) begin
      val_q <= load_val;
      arm_q <= armed;
    end
  end
  assign hit = arm_q && (probe == val_q);
endmodule : etmm_brk_cmp

//--- etmm_core.sv
// Trace buffer, cycle counter, memory map and break logic
`timescale 1ns/1ps
`include "etmm_defs.svh"
// Contract
// - Capture instruction, PC, ports, status each executed cycle while running; only the high half of port 2 is kept
// - Trace holds 255 entries of 44 bits
// - Resettable counter counts executed instruction cycles
// - Program space mapped in sixteen 256-byte blocks
// - One 256-byte external data block, single unit
// - Per-block select routes to emulator or target
// - Up to 384 bytes replacement data memory
// - Trace stays readable after any emulation stop
// - Break on first write to chosen address
// - Three 15-bit break comparators stop emulation
// - Match still output when break disabled
module etmm_core #(
  parameter int DEPTH = `ETMM_TRACE_DEPTH,
  parameter int TW = `ETMM_TRACE_WIDTH,
  parameter int NBLK = `ETMM_PROG_BLOCKS,
  parameter int DBYTES = `ETMM_DATA_BYTES,
  parameter int CW = `ETMM_CYC_WIDTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic run_req,
  input wire logic stop_req,
  input wire logic err_stop,
  input wire logic cycle_stb,
  input wire logic [7:0] instr,
  input wire logic [11:0] pc,
  input wire logic [7:0] bus0,
  input wire logic [7:0] port1,
  input wire logic [7:0] port2,
  input wire logic [3:0] status_lines,
  input wire logic cyc_clr,
  input wire logic map_wr,
  input wire logic [NBLK-1:0] prog_map,
  input wire logic data_map,
  input wire logic [11:0] prog_addr,
  input wire logic xdata_acc,
  input wire logic xdata_wr,
  input wire logic [7:0] xaddr,
  input wire logic [7:0] dwr_data,
  input wire logic [8:0] dmem_addr,
  input wire logic dmem_wr,
  input wire logic brk_en,
  input wire logic brk_load,
  input wire logic [1:0] brk_sel,
  input wire logic [14:0] brk_val,
  input wire logic brk_arm,
  input wire logic wbrk_load,
  input wire logic [7:0] wbrk_addr,
  input wire logic wbrk_arm,
  input wire logic [7:0] trace_raddr,
  output logic [TW-1:0] trace_rdata,
  output logic [7:0] trace_wptr,
  output logic trace_wrapped,
  output logic [CW-1:0] cyc_count,
  output logic prog_emu,
  output logic xdata_emu,
  output logic [7:0] dmem_rdata,
  output logic running,
  output logic brk_match,
  output logic halted
);
  localparam logic [7:0] LAST = 8'(DEPTH - 1);
  etmm_pkg::etmm_state_t st_q;
  logic [TW-1:0] trace_mem [DEPTH];
  logic [7:0] dmem [DBYTES];
  logic [7:0] wptr_q;
  logic [NBLK-1:0] pmap_q;
  logic dmap_q;
  logic [7:0] wbrk_q;
  logic wbrk_arm_q;
  logic [2:0] hit;
  logic [14:0] probe;
  logic wr_hit;
  logic any_match;
  logic cap;
  etmm_pkg::etmm_entry_t ent;

  assign cap = ce && cycle_stb && (st_q == etmm_pkg::ETMM_RUN);
  // Status low bits share the comparator word with the address
  assign probe = {status_lines[2:0], pc};
  assign wr_hit = wbrk_arm_q && xdata_acc && xdata_wr && (xaddr == wbrk_q);
  assign any_match = (|hit) || wr_hit;

  genvar g;
  for (g = 0; g < `ETMM_BRK_COUNT; g++) begin : g_brk
    etmm_brk_cmp #(.W(`ETMM_BRK_WIDTH)) u_cmp (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .load(brk_load && (brk_sel == 2'(g))),
      .load_val(brk_val),
      .armed(brk_arm),
      .probe(probe),
      .hit(hit[g])
    );
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= etmm_pkg::ETMM_IDLE;
    end else if (ce) begin
      unique case (st_q)
        etmm_pkg::ETMM_IDLE, etmm_pkg::ETMM_STOP: begin
          if (run_req) begin
            st_q <= etmm_pkg::ETMM_RUN;
          end
        end
        etmm_pkg::ETMM_RUN: begin
          // Break only counts on a real cycle; trace is never cleared
          if (stop_req || err_stop ||
              (cycle_stb && brk_en && any_match)) begin
            st_q <= etmm_pkg::ETMM_STOP;
          end
        end
        default: st_q <= etmm_pkg::ETMM_IDLE;
      endcase
    end
  end

  always_comb begin
    ent.instr = instr;
    ent.pc = pc;
    ent.bus0 = bus0;
    ent.port1 = port1;
    ent.port2 = port2;
  end

  always_ff @(posedge mclk) begin
    if (cap) begin
      // 44 bits: the status nibble takes the low half of port 2
      trace_mem[wptr_q] <= {status_lines, ent[43:4]};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wptr_q <= `ETMM_PTR_RST;
      trace_wrapped <= 1'b0;
    end else if (cap) begin
      if (wptr_q == LAST) begin
        wptr_q <= `ETMM_PTR_RST;
        trace_wrapped <= 1'b1;
      end else begin
        wptr_q <= wptr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      trace_rdata <= '0;
      trace_wptr <= `ETMM_PTR_RST;
    end else if (ce) begin
      trace_rdata <= (trace_raddr <= LAST) ? trace_mem[trace_raddr] : '0;
      trace_wptr <= wptr_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || (ce && cyc_clr)) begin
      cyc_count <= `ETMM_CYC_RST;
    end else if (cap) begin
      cyc_count <= cyc_count + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pmap_q <= '0;
      dmap_q <= 1'b0;
      wbrk_q <= 8'h00;
      wbrk_arm_q <= 1'b0;
    end else if (ce) begin
      if (map_wr) begin
        pmap_q <= prog_map;
        dmap_q <= data_map;
      end
      if (wbrk_load) begin
        wbrk_q <= wbrk_addr;
        wbrk_arm_q <= wbrk_arm;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prog_emu <= 1'b0;
      xdata_emu <= 1'b0;
    end else if (ce) begin
      prog_emu <= pmap_q[prog_addr[11:8]];
      xdata_emu <= dmap_q && xdata_acc;
    end
  end

  // Internal bytes first, external block after; writes beyond are dropped, reads return 0
  always_ff @(posedge mclk) begin
    if (ce && dmem_wr && (dmem_addr < 9'(DBYTES))) begin
      dmem[dmem_addr] <= dwr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dmem_rdata <= 8'h00;
    end else if (ce) begin
      dmem_rdata <= (dmem_addr < 9'(DBYTES)) ? dmem[dmem_addr] : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      running <= 1'b0;
      halted <= 1'b0;
      brk_match <= 1'b0;
    end else if (ce) begin
      running <= (st_q == etmm_pkg::ETMM_RUN);
      halted <= (st_q == etmm_pkg::ETMM_STOP);
      // Match pulses regardless of break enable for external tools
      brk_match <= (st_q == etmm_pkg::ETMM_RUN) && cycle_stb &&
                   any_match;
    end
  end

  stop_on_brk_a: assert property (@(posedge mclk)
    disable iff (srst)
    ce && st_q == etmm_pkg::ETMM_RUN && cycle_stb && brk_en && any_match
    |=> st_q == etmm_pkg::ETMM_STOP) else $error("break did not stop");
  // A user or error stop in the same cycle may still end the run
  match_nobrk_a: assert property (@(posedge mclk)
    disable iff (srst)
    ce && st_q == etmm_pkg::ETMM_RUN && cycle_stb && !brk_en && any_match
    |=> brk_match &&
    (st_q == etmm_pkg::ETMM_RUN || $past(stop_req || err_stop)))
    else $error("match lost or halted");
  wr_brk_a: assert property (@(posedge mclk)
    disable iff (srst)
    ce && st_q == etmm_pkg::ETMM_RUN && cycle_stb && brk_en && wr_hit
    |=> halted == 1'b0 ##1 halted) else $error("write break missed");
  ptr_wrap_a: assert property (@(posedge mclk)
    disable iff (srst)
    cap && wptr_q == LAST |=> wptr_q == 8'h00 && trace_wrapped)
    else $error("pointer wrap wrong");
  ptr_step_a: assert property (@(posedge mclk)
    disable iff (srst)
    cap && wptr_q != LAST |=> wptr_q == $past(wptr_q) + 8'h01)
    else $error("pointer step wrong");
  ptr_hold_a: assert property (@(posedge mclk)
    disable iff (srst)
    st_q == etmm_pkg::ETMM_STOP |=> $stable(wptr_q))
    else $error("trace moved after stop");
  cyc_cnt_a: assert property (@(posedge mclk)
    disable iff (srst)
    cap && !cyc_clr |=> cyc_count == $past(cyc_count) + 1'b1)
    else $error("cycle count wrong");
  cyc_clr_a: assert property (@(posedge mclk)
    disable iff (srst)
    ce && cyc_clr |=> cyc_count == `ETMM_CYC_RST)
    else $error("cycle clear failed");
  // Select in force at the edge decides, even on a map load cycle
  map_sel_a: assert property (@(posedge mclk)
    disable iff (srst)
    ce |=> prog_emu == $past(pmap_q[prog_addr[11:8]]))
    else $error("block select wrong");
  cap_entry_a: assert property (@(posedge mclk)
    disable iff (srst)
    cap |=> trace_mem[$past(wptr_q)] == $past({status_lines, ent[43:4]}))
    else $error("trace entry wrong");
endmodule : etmm_core

//--- etmm_target_model.sv
// Target board model that feeds executed instruction cycles
`timescale 1ns/1ps
module etmm_target_model (
  input wire logic mclk,
  input wire logic req,
  input wire logic [11:0] req_pc,
  output logic cycle_stb,
  output logic [7:0] instr,
  output logic [11:0] pc,
  output logic [7:0] bus0,
  output logic [7:0] port1,
  output logic [7:0] port2,
  output logic [3:0] status_lines
);
  assign status_lines = 4'h5;
  initial begin
    {cycle_stb, instr, pc, bus0, port1, port2} = '0;
  end
  // Lines toggle between cycles so stale data never looks valid
  always @(negedge mclk) begin
    cycle_stb <= req;
    if (req) begin
      pc <= req_pc;
      instr <= req_pc[7:0];
      bus0 <= req_pc[7:0] ^ 8'h5a;
      port1 <= ~req_pc[7:0];
      port2 <= req_pc[11:4];
    end else begin
      pc <= ~pc;
      instr <= ~instr;
      bus0 <= ~bus0;
      port1 <= ~port1;
      port2 <= ~port2;
    end
  end
endmodule : etmm_target_model

//--- emulator_trace_and_memory_map_tb_top.sv
// Self-checking bench for the trace and memory map block
`timescale 1ns/1ps
module emulator_trace_and_memory_map_tb_top;
  logic mclk, srst, ce, run_req, stop_req, err_stop, cycle_stb, cyc_clr;
  logic map_wr, data_map, xdata_acc, xdata_wr, dmem_wr, brk_en, brk_load;
  logic brk_arm, wbrk_load, wbrk_arm, req;
  logic [7:0] instr, bus0, port1, port2, xaddr, dwr_data, wbrk_addr;
  logic [7:0] trace_raddr, trace_wptr, dmem_rdata;
  logic [11:0] pc, prog_addr, req_pc;
  logic [3:0] status_lines;
  logic [15:0] prog_map;
  logic [8:0] dmem_addr;
  logic [1:0] brk_sel;
  logic [14:0] brk_val;
  logic [43:0] trace_rdata;
  logic [31:0] cyc_count;
  logic trace_wrapped, prog_emu, xdata_emu, running, brk_match, halted;
  int mismatches = 0;
  int compares = 0;
  int hits = 0;
  etmm_core dut_u (.mclk(mclk), .srst(srst), .ce(ce), .run_req(run_req),
    .stop_req(stop_req), .err_stop(err_stop), .cycle_stb(cycle_stb),
    .instr(instr), .pc(pc), .bus0(bus0), .port1(port1), .port2(port2),
    .status_lines(status_lines), .cyc_clr(cyc_clr), .map_wr(map_wr),
    .prog_map(prog_map), .data_map(data_map), .prog_addr(prog_addr),
    .xdata_acc(xdata_acc), .xdata_wr(xdata_wr), .xaddr(xaddr),
    .dwr_data(dwr_data), .dmem_addr(dmem_addr), .dmem_wr(dmem_wr),
    .brk_en(brk_en), .brk_load(brk_load), .brk_sel(brk_sel),
    .brk_val(brk_val), .brk_arm(brk_arm), .wbrk_load(wbrk_load),
    .wbrk_addr(wbrk_addr), .wbrk_arm(wbrk_arm),
    .trace_raddr(trace_raddr), .trace_rdata(trace_rdata),
    .trace_wptr(trace_wptr), .trace_wrapped(trace_wrapped),
    .cyc_count(cyc_count), .prog_emu(prog_emu), .xdata_emu(xdata_emu),
    .dmem_rdata(dmem_rdata), .running(running), .brk_match(brk_match),
    .halted(halted));
  etmm_target_model tgt_u (.mclk(mclk), .req(req), .req_pc(req_pc),
    .cycle_stb(cycle_stb), .instr(instr), .pc(pc), .bus0(bus0),
    .port1(port1), .port2(port2), .status_lines(status_lines));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (brk_match === 1'b1) hits++;
  task give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [43:0] got, input logic [43:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task go();
    run_req <= 1;
    cyc(1);
    run_req <= 0;
  endtask : go
  task step(input logic [11:0] p);
    req <= 1;
    req_pc <= p;
    cyc(1);
    req <= 0;
    cyc(1);
  endtask : step
  // Status, instr, pc, bus 0, port 1, high half of port 2
  function automatic logic [43:0] ent(input logic [11:0] p);
    return {4'h5, p[7:0], p, p[7:0] ^ 8'h5a, ~p[7:0], p[11:8]};
  endfunction : ent
  task rd(input int i, input logic [11:0] p);
    trace_raddr <= i[7:0];
    cyc(3);
    chk(trace_rdata, ent(p));
  endtask : rd
  task dwr(input logic [8:0] a, input logic [7:0] d);
    dmem_addr <= a;
    dwr_data <= d;
    dmem_wr <= 1;
    cyc(1);
    dmem_wr <= 0;
    cyc(1);
  endtask : dwr
  task dchk(input logic [8:0] a, input logic [7:0] e);
    dmem_addr <= a;
    cyc(3);
    chk(dmem_rdata, e);
  endtask : dchk
  task t_trace();
    go();
    cyc(3);
    chk(running, 1);
    for (int k = 0; k < 4; k++) step(12'h100 + k[11:0]);
    cyc(2);
    chk(trace_wptr, 4);
    chk(cyc_count, 4);
    for (int k = 0; k < 4; k++) rd(k, 12'h100 + k[11:0]);
    cyc_clr <= 1;
    cyc(1);
    cyc_clr <= 0;
    cyc(2);
    chk(cyc_count, 0);
    step(12'h200);
    cyc(2);
    chk(cyc_count, 1);
    $display("test trace done");
  endtask : t_trace
  task t_map();
    prog_map <= 16'h00a5;
    data_map <= 1;
    map_wr <= 1;
    cyc(1);
    map_wr <= 0;
    xdata_acc <= 1;
    for (int b = 0; b < 16; b++) begin
      prog_addr <= {b[3:0], 8'h3c};
      cyc(3);
      chk(prog_emu, prog_map[b]);
    end
    chk(xdata_emu, 1);
    data_map <= 0;
    map_wr <= 1;
    cyc(1);
    map_wr <= 0;
    cyc(3);
    chk(xdata_emu, 0);
    xdata_acc <= 0;
    $display("test map done");
  endtask : t_map
  task t_dmem();
    dwr(9'h000, 8'h11);
    dwr(9'h17f, 8'h3c);
    dwr(9'h180, 8'hc3);
    dchk(9'h000, 8'h11);
    dchk(9'h17f, 8'h3c);
    dchk(9'h180, 8'h00);
    $display("test data memory done");
  endtask : t_dmem
  task t_brk();
    brk_sel <= 2'h0;
    brk_val <= {3'h5, 12'h123};
    brk_arm <= 1;
    brk_load <= 1;
    cyc(1);
    brk_load <= 0;
    step(12'h123);
    cyc(3);
    chk(hits, 1);
    chk(running, 1);
    brk_en <= 1;
    step(12'h123);
    cyc(4);
    chk(hits, 2);
    chk(halted, 1);
    chk(running, 0);
    step(12'h300);
    cyc(2);
    chk(trace_wptr, 7);
    rd(6, 12'h123);
    rd(0, 12'h100);
    $display("test break done");
  endtask : t_brk
  task t_stop();
    wbrk_addr <= 8'h42;
    wbrk_arm <= 1;
    wbrk_load <= 1;
    cyc(1);
    wbrk_load <= 0;
    xaddr <= 8'h42;
    xdata_acc <= 1;
    go();
    step(12'h3f0);
    cyc(2);
    chk(running, 1);
    xdata_wr <= 1;
    step(12'h400);
    cyc(4);
    chk(halted, 1);
    chk(running, 0);
    chk(hits, 3);
    xdata_acc <= 0;
    xdata_wr <= 0;
    brk_sel <= 2'h2;
    brk_val <= {3'h5, 12'h6a5};
    brk_load <= 1;
    cyc(1);
    brk_load <= 0;
    go();
    step(12'h6a5);
    cyc(4);
    chk(running, 0);
    chk(hits, 4);
    go();
    step(12'h500);
    chk(running, 1);
    err_stop <= 1;
    cyc(1);
    err_stop <= 0;
    cyc(3);
    chk(halted, 1);
    chk(running, 0);
    go();
    step(12'h600);
    chk(running, 1);
    stop_req <= 1;
    cyc(1);
    stop_req <= 0;
    step(12'h700);
    cyc(2);
    chk(halted, 1);
    chk(trace_wptr, 12);
    rd(11, 12'h600);
    rd(10, 12'h500);
    rd(9, 12'h6a5);
    rd(8, 12'h400);
    $display("test stop done");
  endtask : t_stop
  task t_wrap();
    go();
    for (int k = 0; k < 242; k++) step(12'h800 + k[11:0]);
    cyc(2);
    chk(trace_wrapped, 0);
    chk(trace_wptr, 254);
    for (int k = 242; k < 245; k++) step(12'h800 + k[11:0]);
    cyc(2);
    chk(trace_wrapped, 1);
    chk(trace_wptr, 2);
    chk(cyc_count, 253);
    rd(0, 12'h8f3);
    rd(1, 12'h8f4);
    rd(254, 12'h8f2);
    rd(12, 12'h800);
    trace_raddr <= 8'hff;
    cyc(3);
    chk(trace_rdata, 0);
    $display("test wrap done");
  endtask : t_wrap
  initial begin
    {ce, run_req, stop_req, err_stop, cyc_clr, map_wr, data_map} = '0;
    {xdata_acc, xdata_wr, dmem_wr, brk_en, brk_load, brk_arm} = '0;
    {wbrk_load, wbrk_arm, req, req_pc, xaddr, dwr_data, wbrk_addr} = '0;
    {trace_raddr, prog_addr, prog_map, dmem_addr, brk_sel, brk_val} = '0;
    srst = 1;
    ce = 1;
    cyc(10);
    srst <= 0;
    cyc(2);
    chk(running, 0);
    chk(trace_wptr, 0);
    chk(trace_wrapped, 0);
    chk(cyc_count, 0);
    $display("test reset done");
    t_trace();
    t_map();
    t_dmem();
    t_brk();
    t_stop();
    t_wrap();
    give_verdict();
  end
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule : emulator_trace_and_memory_map_tb_top
